// ===== rtl/thp_cfg.svh
/*
 Offsets, status bit positions and link frame layout of the tape host port.
 Assumes it is included by the package and the port modules by bare name.
*/
// Contract
// - data buffer is 18 bits, loaded by host in parallel or by transport serially
// - low 16 bits act as word buffer for host writes and DMA data words
// - host writes may be full word or single high or low byte
// - data buffer is write-only and never cleared by any reset
// - a host load completes only on a serial clock edge from the transport
// - every host access to either location is answered with slave acknowledge
// - each host load of the data buffer is copied into the address pointer
// - copy maps bits 15-2 straight, bits 1-0 to 17-16, clears 1-0
// - status bits 9 and 8 show address pointer bits 17 and 16
// - transport steps the pointer by two per word, one per byte, up or down
// - transport-requested reads fetch packet words and forward them to the transport
// - transport serial pointer load copies all 18 bits into the address pointer
// - after an ascending word deposit to existing memory the pointer holds last address plus two
// - status is read-only to host; host writes change it only through flag clears, bus parity, pointer bits and the refused flag
// - host write clears serial parity, refused, nonexistent memory and ready flags, loads bus parity from the write
// - packet: command word, address low, address high bits 1-0, byte count
// - command set of status, read, characteristics, write, position, format, control, init
// - only two host word locations: buffer/address and status
// - tape motion commands are rejected until characteristics have been set
`ifndef THP_CFG_SVH
`define THP_CFG_SVH

`define THP_LOC_DB      1'b0
`define THP_LOC_ST      1'b1

`define THP_SR_SERPAR   15
`define THP_SR_BUSPAR   14
`define THP_SR_MODREF   13
`define THP_SR_NXM      12
`define THP_SR_READY    11
`define THP_SR_AEXT_HI  9
`define THP_SR_AEXT_LO  8
`define THP_SR_REJECT   7
`define THP_SR_CHARS    6

`define THP_FRAME_BITS  5'h17
`define THP_REPLY_BITS  5'h11
`define THP_FR_KIND_HI  22
`define THP_FR_KIND_LO  21
`define THP_FR_BYTE     20
`define THP_FR_DEC      19
`define THP_FR_DATA_HI  18
`define THP_FR_DATA_LO  1
`define THP_STAT_READY  7
`define THP_CMD_HI      4

`endif

// ===== rtl/thp_pkg.sv
/*
 Types of the tape host port: sequencer states, link frame kinds, commands.
 Assumes thp_cfg.svh is on the include path.
*/
`include "thp_cfg.svh"

package thp_pkg;

    typedef enum logic [2:0]
    {
        THP_IDLE = 3'h1,
        THP_MEM  = 3'h2,
        THP_TX   = 3'h4
    } thp_state_type;

    typedef enum logic [1:0]
    {
        THP_OP_PTR  = 2'h0,
        THP_OP_STAT = 2'h1,
        THP_OP_RD   = 2'h2,
        THP_OP_WR   = 2'h3
    } thp_op_type;

    typedef enum logic [4:0]
    {
        THP_C_GET_STATUS  = 5'h00,
        THP_C_READ_NEXT   = 5'h01,
        THP_C_READ_PREV   = 5'h02,
        THP_C_REREAD_PREV = 5'h03,
        THP_C_REREAD_NEXT = 5'h04,
        THP_C_WRITE_CHAR  = 5'h05,
        THP_C_WRITE       = 5'h06,
        THP_C_WRITE_RETRY = 5'h07,
        THP_C_SPACE_FWD   = 5'h08,
        THP_C_SPACE_REV   = 5'h09,
        THP_C_SKIP_FWD    = 5'h0A,
        THP_C_SKIP_REV    = 5'h0B,
        THP_C_REWIND      = 5'h0C,
        THP_C_WRITE_MARK  = 5'h0D,
        THP_C_ERASE       = 5'h0E,
        THP_C_MARK_RETRY  = 5'h0F,
        THP_C_MSG_RELEASE = 5'h10,
        THP_C_UNLOAD      = 5'h11,
        THP_C_CLEAN       = 5'h12,
        THP_C_DRIVE_INIT  = 5'h13
    } thp_cmd_type;

endpackage

// ===== rtl/thp_link_sync.sv
/*
 Three-stage synchroniser with agreement filter and edge pulses.
 Assumes inputs come from pins outside the clk domain.
*/
`timescale 1ns/1ns

module thp_link_sync #(
    parameter int W = 3
) (
    input  wire logic         clk,      // system clock
    input  wire logic         rst_n,    // synchronous reset, active low
    input  wire logic [W-1:0] pin_in,   // asynchronous inputs
    output logic      [W-1:0] level,    // filtered level
    output logic      [W-1:0] rise,     // one-cycle pulse on filtered rise
    output logic      [W-1:0] fall      // one-cycle pulse on filtered fall
);

    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;
    logic [W-1:0] filt_reg;
    logic [W-1:0] agree;

    // =====================================================
    // stages and filter
    assign agree = ~(s2_reg ^ s3_reg);
    assign rise  = agree & s3_reg & ~filt_reg;
    assign fall  = agree & ~s3_reg & filt_reg;
    assign level = filt_reg;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            s1_reg   <= '0;
            s2_reg   <= '0;
            s3_reg   <= '0;
            filt_reg <= '0;
        end
        else
        begin
            s1_reg   <= pin_in;
            s2_reg   <= s1_reg;
            s3_reg   <= s2_reg;
            filt_reg <= (agree & s3_reg) | (~agree & filt_reg);
        end
    end

endmodule

// ===== rtl/thp_port.sv
/*
 Host port of the tape subsystem: data buffer, address pointer, status,
 DMA master toward memory and serial link toward the transport.
 Assumes the host holds hb_sel until hb_ssyn, and the transport supplies
 lk_sclk, framing its own sends with lk_rxf and sampling lk_sdo on rises.
*/
`timescale 1ns/1ns
`include "thp_cfg.svh"

module thp_port
    import thp_pkg::*;
(
    input  wire logic        clk,        // system clock
    input  wire logic        rst_n,      // synchronous reset, active low
    input  wire logic        hb_sel,     // host access in progress
    input  wire logic        hb_addr,    // word location select
    input  wire logic        hb_wr,      // 1 write, 0 read
    input  wire logic [1:0]  hb_be,      // byte enables, hi and lo
    input  wire logic [15:0] hb_wdata,   // host write data
    input  wire logic        hb_perr,    // bus parity error on write data
    output logic      [15:0] hb_rdata,   // host read data
    output logic             hb_ssyn,    // slave acknowledge
    output logic             dma_req,    // memory cycle request
    output logic             dma_we,     // memory write
    output logic             dma_byte,   // byte cycle
    output logic      [17:0] dma_addr,   // memory address
    output logic      [15:0] dma_wdata,  // memory write data
    input  wire logic        dma_ack,    // memory cycle done
    input  wire logic        dma_nxm,    // no memory answered, with ack
    input  wire logic [15:0] dma_rdata,  // memory read data, with ack
    input  wire logic        lk_sclk,    // serial clock from transport
    input  wire logic        lk_rxf,     // transport send frame
    input  wire logic        lk_sdi,     // serial data from transport
    output logic             lk_txf,     // reply frame to transport
    output logic             lk_sdo      // serial data to transport
);

    // =====================================================
    // declarations
    thp_state_type state_reg;
    logic [17:0]   db_reg;
    logic [17:0]   ptr_reg;
    logic [15:0]   wbuf_reg;
    logic [1:0]    wbe_reg;
    logic          acc_reg;
    logic          ssyn_reg;
    logic [15:0]   rdata_reg;
    logic          pend_reg;
    logic          perr_reg;
    logic [22:0]   rx_reg;
    logic [4:0]    rxc_reg;
    logic [16:0]   tx_reg;
    logic [4:0]    txc_reg;
    logic          txf_reg;
    logic          sdo_reg;
    logic          byte_reg;
    logic          dec_reg;
    logic          we_reg;
    logic          req_reg;
    logic [1:0]    pidx_reg;
    logic          spe_reg;
    logic          upe_reg;
    logic          rmr_reg;
    logic          nxm_reg;
    logic          ssr_reg;
    logic          rej_reg;
    logic          chars_reg;
    logic [3:0]    tsl_reg;
    logic [2:0]    sy_level;
    logic [2:0]    sy_rise;
    logic [2:0]    sy_fall;

    // =====================================================
    // link synchroniser
    thp_link_sync #(
        .W (3)
    ) u_sync (
        .clk    (clk),
        .rst_n  (rst_n),
        .pin_in ({lk_sdi, lk_rxf, lk_sclk}),
        .level  (sy_level),
        .rise   (sy_rise),
        .fall   (sy_fall)
    );

    wire        sclk_rise = sy_rise[0];
    wire        sclk_fall = sy_fall[0];
    wire        rxf_lvl   = sy_level[1];
    wire        rxf_end   = sy_fall[1];
    wire        sdi_lvl   = sy_level[2];

    // =====================================================
    // functions
    function automatic logic [17:0] step(input logic [17:0] a,
                                         input logic bm, input logic dn);
        logic [17:0] d;
        d = bm ? 18'h00001 : 18'h00002;
        step = dn ? a - d : a + d;
    endfunction

    function automatic logic is_motion(input logic [4:0] c);
        is_motion = !(c == THP_C_GET_STATUS || c == THP_C_WRITE_CHAR ||
                      c == THP_C_MSG_RELEASE || c == THP_C_DRIVE_INIT);
    endfunction

    // =====================================================
    // host decode
    wire        idle      = (state_reg == THP_IDLE);
    wire        acc_new   = hb_sel & ~acc_reg;
    wire        rd_new    = acc_new & ~hb_wr;
    wire        wr_new    = acc_new & hb_wr;
    wire        wr_refuse = wr_new & (~idle | pend_reg);
    wire        wr_take   = wr_new & idle & ~pend_reg;

    // =====================================================
    // link frame decode
    wire        rx_done   = rxf_end & (rxc_reg == `THP_FRAME_BITS) & idle;
    wire        rx_par_ok = ^rx_reg;
    thp_op_type rx_kind;
    assign rx_kind = thp_op_type'(rx_reg[`THP_FR_KIND_HI:`THP_FR_KIND_LO]);
    wire [17:0] rx_data   = rx_reg[`THP_FR_DATA_HI:`THP_FR_DATA_LO];
    wire        rx_ok     = rx_done & rx_par_ok;
    wire        op_ptr    = rx_ok & (rx_kind == THP_OP_PTR);
    wire        op_stat   = rx_ok & (rx_kind == THP_OP_STAT);
    wire        op_rd     = rx_ok & (rx_kind == THP_OP_RD);
    wire        op_wr     = rx_ok & (rx_kind == THP_OP_WR);

    // load only on link clock edge
    wire        wr_go     = pend_reg & sclk_rise & idle & ~rx_done;

    wire [15:0] db_merge;
    assign db_merge[15:8] = wbe_reg[1] ? wbuf_reg[15:8] : db_reg[15:8];
    assign db_merge[7:0]  = wbe_reg[0] ? wbuf_reg[7:0]  : db_reg[7:0];

    wire [17:0] ptr_remap = {db_merge[1:0], db_merge[15:2], 2'h0};

    wire        mem_done  = (state_reg == THP_MEM) & dma_ack;
    wire        mem_ok    = mem_done & ~dma_nxm;
    wire [17:0] ptr_step  = step(ptr_reg, byte_reg, dec_reg);
    wire [4:0]  cmd_code  = dma_rdata[`THP_CMD_HI:0];
    wire        first_rd  = mem_ok & ~we_reg & (pidx_reg == 2'h0);

    // =====================================================
    // status word
    wire [15:0] st_w;
    assign st_w[`THP_SR_SERPAR]  = spe_reg;
    assign st_w[`THP_SR_BUSPAR]  = upe_reg;
    assign st_w[`THP_SR_MODREF]  = rmr_reg;
    assign st_w[`THP_SR_NXM]     = nxm_reg;
    assign st_w[`THP_SR_READY]   = ssr_reg;
    assign st_w[10]              = 1'b0;
    assign st_w[`THP_SR_AEXT_HI] = ptr_reg[17];
    assign st_w[`THP_SR_AEXT_LO] = ptr_reg[16];
    assign st_w[`THP_SR_REJECT]  = rej_reg;
    assign st_w[`THP_SR_CHARS]   = chars_reg;
    assign st_w[5:4]             = 2'h0;
    assign st_w[3:0]             = tsl_reg;

    wire [15:0] rd_mux = (hb_addr == `THP_LOC_ST) ? st_w : ptr_reg[15:0];

    // =====================================================
    // host access and acknowledge
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            acc_reg   <= 1'b0;
            ssyn_reg  <= 1'b0;
            rdata_reg <= 16'h0000;
            pend_reg  <= 1'b0;
            wbuf_reg  <= 16'h0000;
            wbe_reg   <= 2'h0;
            perr_reg  <= 1'b0;
        end
        else
        begin
            if (!hb_sel)
            begin
                acc_reg  <= 1'b0;
                ssyn_reg <= 1'b0;
            end
            else if (acc_new)
                acc_reg <= 1'b1;
            if (rd_new)
                rdata_reg <= rd_mux;
            if (rd_new | wr_refuse | wr_go)
                ssyn_reg <= 1'b1;
            if (wr_take)
            begin
                pend_reg <= 1'b1;
                wbuf_reg <= hb_wdata;
                wbe_reg  <= hb_be;
                perr_reg <= hb_perr;
            end
            else if (wr_go)
                pend_reg <= 1'b0;
        end
    end

    // =====================================================
    // data buffer, never reset
    always_ff @(posedge clk)
    begin
        if (wr_go)
            db_reg[15:0] <= db_merge;
        else if (op_ptr)
            db_reg <= rx_data;
        else if (op_wr)
            db_reg[15:0] <= rx_data[15:0];
        else if (mem_ok && !we_reg)
            db_reg[15:0] <= dma_rdata;
    end

    // =====================================================
    // address pointer
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            ptr_reg <= 18'h00000;
        else if (wr_go)
            ptr_reg <= ptr_remap;
        else if (op_ptr)
            ptr_reg <= rx_data;
        else if (mem_ok)
            ptr_reg <= ptr_step;
    end

    // =====================================================
    // serial receive
    always_ff @(posedge clk)
    begin
        if (!rst_n || !rxf_lvl)
            rxc_reg <= 5'h00;
        else if (sclk_rise && rxc_reg != `THP_FRAME_BITS)
            rxc_reg <= rxc_reg + 5'h01;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            rx_reg <= 23'h000000;
        else if (rxf_lvl && sclk_rise)
            rx_reg <= {rx_reg[21:0], sdi_lvl};
    end

    // =====================================================
    // sequencer
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            state_reg <= THP_IDLE;
            req_reg   <= 1'b0;
            we_reg    <= 1'b0;
            byte_reg  <= 1'b0;
            dec_reg   <= 1'b0;
            tx_reg    <= 17'h00000;
            txc_reg   <= 5'h00;
            txf_reg   <= 1'b0;
            sdo_reg   <= 1'b0;
        end
        else
        begin
            unique case (state_reg)
                THP_IDLE:
                begin
                    if (op_rd || op_wr)
                    begin
                        state_reg <= THP_MEM;
                        req_reg   <= 1'b1;
                        we_reg    <= op_wr;
                        byte_reg  <= rx_reg[`THP_FR_BYTE];
                        dec_reg   <= rx_reg[`THP_FR_DEC];
                    end
                end
                THP_MEM:
                begin
                    if (dma_ack)
                    begin
                        req_reg <= 1'b0;
                        if (mem_ok && !we_reg)
                        begin
                            state_reg <= THP_TX;
                            tx_reg    <= {dma_rdata, ~^dma_rdata};
                            txc_reg   <= 5'h00;
                        end
                        else
                            state_reg <= THP_IDLE;
                    end
                end
                THP_TX:
                begin
                    if (sclk_fall)
                    begin
                        if (txc_reg == `THP_REPLY_BITS)
                        begin
                            txf_reg   <= 1'b0;
                            state_reg <= THP_IDLE;
                        end
                        else
                        begin
                            txf_reg <= 1'b1;
                            sdo_reg <= tx_reg[16];
                            tx_reg  <= {tx_reg[15:0], 1'b0};
                            txc_reg <= txc_reg + 5'h01;
                        end
                    end
                end
            endcase
        end
    end

    // =====================================================
    // packet word index and command screening
    always_ff @(posedge clk)
    begin
        if (!rst_n || wr_go || op_ptr)
            pidx_reg <= 2'h0;
        else if (mem_ok && !we_reg)
            pidx_reg <= pidx_reg + 2'h1;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            chars_reg <= 1'b0;
            rej_reg   <= 1'b0;
        end
        else if (first_rd)
        begin
            if (cmd_code == THP_C_WRITE_CHAR)
                chars_reg <= 1'b1;
            rej_reg <= is_motion(cmd_code) & ~chars_reg;
        end
    end

    // =====================================================
    // status flags: clear first, set wins
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            spe_reg <= 1'b0;
            upe_reg <= 1'b0;
            rmr_reg <= 1'b0;
            nxm_reg <= 1'b0;
            ssr_reg <= 1'b0;
            tsl_reg <= 4'h0;
        end
        else
        begin
            if (wr_go)
            begin
                spe_reg <= 1'b0;
                rmr_reg <= 1'b0;
                nxm_reg <= 1'b0;
                ssr_reg <= 1'b0;
                upe_reg <= perr_reg;
            end
            if (rx_done && !rx_par_ok)
                spe_reg <= 1'b1;
            if (wr_refuse)
                rmr_reg <= 1'b1;
            if (mem_done && dma_nxm)
                nxm_reg <= 1'b1;
            if (op_stat)
            begin
                tsl_reg <= rx_data[3:0];
                if (rx_data[`THP_STAT_READY])
                    ssr_reg <= 1'b1;
            end
        end
    end

    // =====================================================
    // outputs
    assign hb_rdata  = rdata_reg;
    assign hb_ssyn   = ssyn_reg;
    assign dma_req   = req_reg;
    assign dma_we    = we_reg;
    assign dma_byte  = byte_reg;
    assign dma_addr  = ptr_reg;
    assign dma_wdata = db_reg[15:0];
    assign lk_txf    = txf_reg;
    assign lk_sdo    = sdo_reg;

endmodule

// ===== tb/thp_port_monitor.sv
/*
 Checker of the tape host port, fed from the top ports only.
 Assumes it is bound onto thp_port, one clock domain.
*/
`timescale 1ns/1ns

module thp_port_monitor (
    input wire logic        clk,       // system clock
    input wire logic        rst_n,     // synchronous reset, active low
    input wire logic        hb_sel,    // host access
    input wire logic        hb_addr,   // word location
    input wire logic        hb_wr,     // host write
    input wire logic [1:0]  hb_be,     // byte enables
    input wire logic [15:0] hb_wdata,  // host write data
    input wire logic [15:0] hb_rdata,  // host read data
    input wire logic        hb_ssyn,   // slave acknowledge
    input wire logic        dma_req,   // memory request
    input wire logic        dma_we,    // memory write
    input wire logic        dma_byte,  // byte cycle
    input wire logic [17:0] dma_addr,  // address pointer
    input wire logic        dma_ack,   // memory done
    input wire logic        dma_nxm    // no memory
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // ====
    // host side
    AST_READ_ACK: assert property ($rose(hb_sel) && !hb_wr |=> hb_ssyn)
        else $error("read not acknowledged in one cycle");
    AST_SSYN_DROP: assert property (hb_ssyn && !hb_sel |=> !hb_ssyn)
        else $error("acknowledge held after release");
    AST_PTR_REMAP: assert property ($rose(hb_ssyn) && hb_wr && hb_be == 2'b11
        && $past(hb_sel, 2) |-> dma_addr == {hb_wdata[1:0], hb_wdata[15:2], 2'b00})
        else $error("pointer not remapped");
    AST_SR_EXT: assert property (hb_ssyn && hb_sel && !hb_wr && hb_addr
        |-> hb_rdata[9:8] == dma_addr[17:16])
        else $error("status extension wrong");

    // ====
    // memory side
    AST_DMA_STEP: assert property (dma_req && dma_ack && !dma_nxm |=>
        (dma_addr - $past(dma_addr)) == ($past(dma_byte) ? 18'h00001 : 18'h00002)
        || ($past(dma_addr) - dma_addr) == ($past(dma_byte) ? 18'h00001 : 18'h00002))
        else $error("pointer step wrong after transfer");
    AST_REQ_HOLD: assert property (dma_req && !dma_ack |=>
        dma_req && $stable(dma_addr) && $stable(dma_we))
        else $error("request changed before ack");
    AST_REQ_DROP: assert property (dma_req && dma_ack |=> !dma_req)
        else $error("memory request held after answer");
    AST_NXM_HOLD: assert property (dma_req && dma_ack && dma_nxm |=> $stable(dma_addr))
        else $error("pointer stepped on missing memory");

    cover property ($rose(hb_ssyn) && hb_wr);
    cover property (dma_ack && dma_we);
    cover property (dma_ack && dma_byte);
endmodule

bind thp_port thp_port_monitor u_mon (.clk(clk), .rst_n(rst_n), .hb_sel(hb_sel),
    .hb_addr(hb_addr), .hb_wr(hb_wr), .hb_be(hb_be), .hb_wdata(hb_wdata),
    .hb_rdata(hb_rdata), .hb_ssyn(hb_ssyn), .dma_req(dma_req), .dma_we(dma_we),
    .dma_byte(dma_byte), .dma_addr(dma_addr), .dma_ack(dma_ack), .dma_nxm(dma_nxm));

// ===== tb/thp_mem_model.sv
/*
 Host memory answering the port's DMA cycles, 64 words.
 Assumes one request at a time, held until the answer.
*/
`timescale 1ns/1ns

module thp_mem_model (
    input  wire logic        clk,        // system clock
    input  wire logic        rst_n,      // reset, active low
    input  wire logic        slow,       // long latency
    input  wire logic        dma_req,    // memory request
    input  wire logic        dma_we,     // memory write
    input  wire logic [17:0] dma_addr,   // address
    input  wire logic [15:0] dma_wdata,  // write data
    output logic             dma_ack,    // done pulse
    output logic             dma_nxm,    // no memory
    output logic      [15:0] dma_rdata   // read data
);
    logic [15:0] mem [0:63];
    logic [5:0]  wait_reg;
    wire         hit = dma_req && !dma_ack && wait_reg == (slow ? 6'h28 : 6'h02);

    assign dma_nxm = &dma_addr[17:16];

    // ====
    // answer DMA reads and writes
    always @(posedge clk)
    begin
        wait_reg  <= (!rst_n || hit || !dma_req) ? 6'h00 : wait_reg + 6'h01;
        dma_ack   <= rst_n && hit;
        dma_rdata <= (hit && !dma_we) ? mem[dma_addr[6:1]] : ~dma_rdata;
        if (hit && dma_we)
            mem[dma_addr[6:1]] <= dma_wdata;
    end
endmodule

// ===== tb/thp_port_test.sv
/*
 Self-checking bench of the tape host port with host memory model.
 Assumes the bench plays host and transport; link clock 48 ns, 60 ns per bit while sending a frame.
*/
`timescale 1ns/1ns

module thp_port_test
    import thp_pkg::*;
;
    logic        clk = 0, rst_n = 0, hb_sel = 0, hb_addr = 0, hb_wr = 0, hb_perr = 0;
    logic [1:0]  hb_be = 0;
    logic [15:0] hb_wdata = 0, hb_rdata, dma_wdata, dma_rdata;
    logic        lk_sclk = 0, lk_rxf = 0, lk_sdi = 0, slow = 1, lk_txf, lk_sdo;
    logic        hb_ssyn, dma_req, dma_we, dma_byte, dma_ack, dma_nxm;
    logic [17:0] dma_addr;
    logic [16:0] rx;
    int          rxn, err_count = 0, n_tests = 0;

    always #2 clk = ~clk;

    thp_port dut (.clk(clk), .rst_n(rst_n), .hb_sel(hb_sel), .hb_addr(hb_addr),
        .hb_wr(hb_wr), .hb_be(hb_be), .hb_wdata(hb_wdata), .hb_perr(hb_perr),
        .hb_rdata(hb_rdata), .hb_ssyn(hb_ssyn), .dma_req(dma_req), .dma_we(dma_we),
        .dma_byte(dma_byte), .dma_addr(dma_addr), .dma_wdata(dma_wdata),
        .dma_ack(dma_ack), .dma_nxm(dma_nxm), .dma_rdata(dma_rdata), .lk_sclk(lk_sclk),
        .lk_rxf(lk_rxf), .lk_sdi(lk_sdi), .lk_txf(lk_txf), .lk_sdo(lk_sdo));
    thp_mem_model u_mem (.clk(clk), .rst_n(rst_n), .slow(slow), .dma_req(dma_req),
        .dma_we(dma_we), .dma_addr(dma_addr), .dma_wdata(dma_wdata), .dma_ack(dma_ack),
        .dma_nxm(dma_nxm), .dma_rdata(dma_rdata));

    // ====
    // common tasks
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic check(input string what, input logic [17:0] seen, exp);
        n_tests++;
        if (seen !== exp)
        begin
            err_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic tick();
        if (lk_txf === 1'b1)
        begin
            rx = {rx[15:0], lk_sdo};
            rxn++;
        end
        lk_sclk <= 1'b1;
        cyc(6);
        lk_sclk <= 1'b0;
        cyc(6);
    endtask
    task automatic hb_go(input logic a, w, input logic [1:0] be, input logic [15:0] d,
                         input logic pe);
        hb_sel <= 1'b1;
        hb_addr <= a;
        hb_wr <= w;
        hb_be <= be;
        hb_wdata <= d;
        hb_perr <= pe;
    endtask
    task automatic hb_done();
        hb_sel <= 1'b0;
        cyc(3);
    endtask
    task automatic wait_ssyn(input bit run, output logic ok);
        for (int i = 0; i < 6 && hb_ssyn !== 1'b1; i++)
            if (run) tick(); else cyc(12);
        ok = hb_ssyn;
    endtask
    task automatic hb_write(input logic [1:0] be, input logic [15:0] d, input logic pe);
        logic ok;
        hb_go(1'b0, 1'b1, be, d, pe);
        wait_ssyn(1'b1, ok);
        if (ok !== 1'b1)
        begin
            err_count++;
            finish_test();
        end
        else
            hb_done();
    endtask
    task automatic hb_read(input logic a, output logic [15:0] d);
        hb_go(a, 1'b0, 2'b00, 16'h0000, 1'b0);
        cyc(3);
        check("read ack", hb_ssyn, 1'b1);
        d = hb_rdata;
        hb_done();
    endtask
    task automatic frame(input logic [1:0] k, input logic bs, dn, input logic [17:0] d);
        logic [22:0] f;
        f = {k, bs, dn, d, ~(^{k, bs, dn, d})};
        lk_rxf <= 1'b1;
        cyc(6);
        for (int i = 22; i >= 0; i--)
        begin
            lk_sdi <= f[i];
            cyc(3);
            tick();
        end
        lk_rxf <= 1'b0;
        lk_sdi <= ~f[0];
        cyc(8);
    endtask

    // ====
    // scenarios
    task automatic t_load();
        logic        ok;
        logic [15:0] v;
        hb_read(1'b1, v);
        check("status at reset", v, 16'h0000);
        hb_go(1'b0, 1'b1, 2'b11, 16'hABCD, 1'b0);
        wait_ssyn(1'b0, ok);
        check("still clock load", ok, 1'b0);
        wait_ssyn(1'b1, ok);
        check("load ack", ok, 1'b1);
        hb_done();
        hb_read(1'b0, v);
        check("pointer low", v, 16'hABCC);
        hb_read(1'b1, v);
        check("status after load", v[15:6], 10'h004);
        hb_write(2'b10, 16'h12FF, 1'b0);
        hb_write(2'b01, 16'hFF37, 1'b0);
        hb_read(1'b0, v);
        check("byte merge", v, 16'h1234);
        hb_read(1'b1, v);
        check("merged extension", v[9:8], 2'b11);
        frame(2'h3, 1'b0, 1'b0, 18'h00000);
        cyc(50);
        hb_read(1'b1, v);
        check("no memory", v[12], 1'b1);
    endtask
    task automatic t_fetch(input logic [4:0] code, input logic chk7, input logic [1:0] st);
        logic        ok;
        logic [15:0] v, w;
        w = {11'h000, code};
        u_mem.mem[8] = w;
        u_mem.mem[9] = 16'h0040;
        u_mem.mem[10] = 16'h0000;
        u_mem.mem[11] = 16'h0004;
        // host hands over the pointer only
        hb_write(2'b11, 16'h0010, 1'b0);
        frame(2'h2, 1'b0, 1'b0, 18'h00000);
        hb_go(1'b0, 1'b1, 2'b11, 16'h0020, 1'b0);
        wait_ssyn(1'b0, ok);
        check("refused ack", ok, 1'b1);
        hb_done();
        hb_read(1'b1, v);
        check("refused flag", v[13], 1'b1);
        rxn = 0;
        repeat (24) tick();
        check("reply bits", 18'(rxn), 18'd17);
        check("reply word", rx, {w, ~(^w)});
        hb_read(1'b0, v);
        check("fetch step", v, 16'h0012);
        hb_read(1'b1, v);
        check("command state", {chk7 & v[7], v[6]}, st);
        hb_write(2'b11, 16'h0010, 1'b1);
        hb_read(1'b1, v);
        check("flags after write", v[15:11], 5'b01000);
    endtask
    task automatic t_link();
        logic [15:0] v;
        slow = 0;
        frame(2'h0, 1'b0, 1'b0, 18'h20040);
        hb_read(1'b0, v);
        check("link pointer", v, 16'h0040);
        hb_read(1'b1, v);
        check("link extension", v[9:8], 2'b10);
        frame(2'h3, 1'b0, 1'b0, 18'h05A5A);
        cyc(20);
        check("deposit", u_mem.mem[32], 16'h5A5A);
        hb_read(1'b0, v);
        check("deposit end", v, 16'h0042);
        frame(2'h3, 1'b1, 1'b1, 18'h000C3);
        cyc(20);
        hb_read(1'b0, v);
        check("byte step down", v, 16'h0041);
    endtask

    initial
    begin
        cyc(20);
        rst_n <= 1'b1;
        cyc(4);
        t_load();
        t_fetch(THP_C_READ_NEXT, 1'b1, 2'b10);
        t_fetch(THP_C_WRITE_CHAR, 1'b0, 2'b01);
        t_fetch(THP_C_REWIND, 1'b1, 2'b01);
        t_link();
        finish_test();
    end
endmodule
